/* include/nfc_regs.svh */
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
// clock 100 MHz, period in ns
`define NFC_CLK_NS 10
// strobe phase lengths in ns and derived cycle counts (least times round up)
`define NFC_STROBE_NS 20
`define NFC_STROBE_CYC ((`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
// write high to busy, max 100 ns
`define NFC_WB_NS 100
`define NFC_WB_CYC ((`NFC_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
// data hold after rising read strobe in normal output mode
`define NFC_RHOH_NS 25
// worst-case busy times in us
`define NFC_T_PROG_US 700
`define NFC_T_STAGE_US 1
`define NFC_T_LOAD1_US 120
`define NFC_T_LOADM_US 200
`define NFC_T_ERASE_US 10000
`define NFC_T_RST_US 500
`define NFC_US_CYC (1000 / `NFC_CLK_NS)
// partial program limit per page
`define NFC_MAX_PARTIAL 3'h4
// ecc status sectors per page
`define NFC_ECC_SECTORS 3'h4
// command codes
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_STATUS_MP 8'h71
`define NFC_CMD_ECC 8'h7a
`define NFC_CMD_RESET 8'hff
`endif

/* include/nfc_pkg.sv */
package nfc_pkg;
  typedef enum logic [2:0] {
    NFC_OP_CMD,
    NFC_OP_ADDR,
    NFC_OP_WDATA,
    NFC_OP_RDATA,
    NFC_OP_WAIT,
    NFC_OP_ECC
  } nfc_op_t;
  typedef enum logic [2:0] {
    NFC_BUSY_PROG,
    NFC_BUSY_STAGE,
    NFC_BUSY_LOAD1,
    NFC_BUSY_LOADM,
    NFC_BUSY_ERASE,
    NFC_BUSY_RESET
  } nfc_busy_t;
  typedef struct packed {
    nfc_op_t op;
    nfc_busy_t busy_kind;
    logic [7:0] data;
    logic program_page;
    logic new_erase;
  } nfc_req_t;
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic output_strobe_n;
  } nfc_ctl_t;
endpackage

/* hw/nfc_host.sv */
`timescale 1ns/100ps
// Overview of operation
// R1: single-page program busy ends within 700 us, else timeout.
// R2: multi-page final program busy ends within 700 us.
// R3: busy after intermediate 11h confirm lasts at most 1 us.
// R4: host programs one page at most four times before block erase.
// R5: single-page array load busy ends within 120 us.
// R6: multi-page array load busy ends within 200 us.
// R7: reset completes within 500 us worst case.
// R8: with long strobe high, data is sampled before the rising edge.
// R9: short strobe high time keeps data past rising edge.
// R10: device releases outputs on latch enable, chip select or write strobe.
// R11: host fetches four ecc sector status bytes per ecc status read.
// R12: ecc status read only after ready and before data or command; data reads here do not close the ecc window.
// R13: host never drives the byte port while the device drives it.
// R14: status read uses 70h or 71h and returns one byte.
// R15: command byte latched on write strobe rise with command latch high.
// R16: address byte latched on write strobe rise with address latch high.
// R17: ready/busy low during operations, high when done.
// R18: each read strobe fall yields next byte.
// R19: erase busy is bounded; host waits with a timeout.
// R20: every busy wait has a timeout from maximum time; expiry flags error.
`include "nfc_regs.svh"
module nfc_host
  import nfc_pkg::*;
#(
  parameter int unsigned T_PROG_CYC = `NFC_T_PROG_US * `NFC_US_CYC,
  parameter int unsigned T_LOAD1_CYC = `NFC_T_LOAD1_US * `NFC_US_CYC,
  parameter int unsigned T_LOADM_CYC = `NFC_T_LOADM_US * `NFC_US_CYC,
  parameter int unsigned T_ERASE_CYC = `NFC_T_ERASE_US * `NFC_US_CYC,
  parameter int unsigned T_RST_CYC = `NFC_T_RST_US * `NFC_US_CYC
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_req_valid,
  input wire nfc_req_t i_req,
  output logic o_req_ready,
  output logic o_rdata_valid,
  output logic [7:0] o_rdata,
  output logic o_timeout,
  output logic o_partial_limit,
  output nfc_ctl_t o_ctl,
  output logic [7:0] o_io_out,
  output logic o_io_oe,
  input wire logic [7:0] i_io_in,
  input wire logic i_op_status_pin
);
  localparam int unsigned STAGE_CYC = `NFC_T_STAGE_US * `NFC_US_CYC;
  localparam logic [3:0] STROBE_CYC = 4'(`NFC_STROBE_CYC);
  localparam logic [3:0] WB_CYC = 4'(`NFC_WB_CYC);
  // the stage wait is fixed, so the counter must also hold it when erase is short
  localparam int unsigned TMO_MAX = (T_ERASE_CYC > STAGE_CYC) ? T_ERASE_CYC : STAGE_CYC;
  localparam int unsigned TMO_W = $clog2(TMO_MAX + 1);
  if (T_PROG_CYC < 1 || T_LOAD1_CYC < 1 || T_LOADM_CYC < 1 || T_ERASE_CYC < 1 ||
      T_RST_CYC < 1 || T_ERASE_CYC < T_PROG_CYC || T_ERASE_CYC < T_RST_CYC ||
      T_ERASE_CYC < T_LOADM_CYC || T_ERASE_CYC < T_LOAD1_CYC) begin
    $error("nfc_host: timeout counts must be nonzero and erase the largest");
  end

  typedef enum logic [2:0] {
    NFC_IDLE,
    NFC_SETUP,
    NFC_PULSE,
    NFC_HOLD,
    NFC_WB,
    NFC_BUSY
  } nfc_st_t;

  nfc_st_t st_reg, st_next;
  nfc_req_t req_reg, req_next;
  nfc_ctl_t ctl_reg, ctl_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [TMO_W-1:0] tmo_reg, tmo_next;
  logic [2:0] ecc_reg, ecc_next;
  logic [2:0] part_reg, part_next;
  logic [7:0] io_reg, io_next;
  logic oe_reg, oe_next;
  logic rdy_reg, rdy_next;
  logic rv_reg, rv_next;
  logic [7:0] rd_reg, rd_next;
  logic err_reg, err_next;
  logic lim_reg, lim_next;
  logic ecc_open_reg, ecc_open_next;

  function automatic logic [TMO_W-1:0] busy_limit(input nfc_busy_t k);
    logic [TMO_W-1:0] v;
    v = TMO_W'(TMO_MAX);
    unique case (k)
      NFC_BUSY_PROG: v = TMO_W'(T_PROG_CYC); // R1 R2
      NFC_BUSY_STAGE: v = TMO_W'(STAGE_CYC); // R3
      NFC_BUSY_LOAD1: v = TMO_W'(T_LOAD1_CYC); // R5
      NFC_BUSY_LOADM: v = TMO_W'(T_LOADM_CYC); // R6
      NFC_BUSY_ERASE: v = TMO_W'(T_ERASE_CYC); // R19
      NFC_BUSY_RESET: v = TMO_W'(T_RST_CYC); // R7
      default: v = TMO_W'(TMO_MAX);
    endcase
    return v;
  endfunction

  always_comb begin
    st_next = st_reg;
    req_next = req_reg;
    ctl_next = ctl_reg;
    cnt_next = cnt_reg;
    tmo_next = tmo_reg;
    ecc_next = ecc_reg;
    part_next = part_reg;
    io_next = io_reg;
    oe_next = oe_reg;
    rdy_next = rdy_reg;
    rv_next = 1'b0;
    rd_next = rd_reg;
    err_next = err_reg;
    lim_next = lim_reg;
    ecc_open_next = ecc_open_reg;
    unique case (st_reg)
      NFC_IDLE: begin
        if (i_req_valid && rdy_reg) begin
          req_next = i_req;
          rdy_next = 1'b0;
          err_next = 1'b0;
          cnt_next = STROBE_CYC;
          ctl_next.ce_n = 1'b0;
          ctl_next.cle = (i_req.op == NFC_OP_CMD);
          ctl_next.ale = (i_req.op == NFC_OP_ADDR);
          if (i_req.new_erase) begin
            part_next = 3'h0;
          end
          // every request except data reads, ecc reads and the 7Ah command issued while ready closes the ecc status window
          if (i_req.op != NFC_OP_RDATA && i_req.op != NFC_OP_ECC) begin
            ecc_open_next = 1'b0; // R12
          end
          if (i_req.op == NFC_OP_CMD && i_req.data == `NFC_CMD_ECC) begin
            ecc_open_next = 1'b1; // R12
            ecc_next = `NFC_ECC_SECTORS; // R11
          end
          if (i_req.op == NFC_OP_WAIT) begin
            tmo_next = busy_limit(i_req.busy_kind);
            st_next = NFC_BUSY;
          end else if (i_req.op == NFC_OP_ECC && !ecc_open_reg) begin
            rdy_next = 1'b1; // R12
            lim_next = 1'b1;
            st_next = NFC_IDLE;
          end else if (i_req.op == NFC_OP_CMD && i_req.data == `NFC_CMD_ECC &&
                       !i_op_status_pin) begin
            // ecc status may only follow a completed operation
            ecc_open_next = 1'b0; // R12
            rdy_next = 1'b1;
            lim_next = 1'b1;
          end else if (i_req.op == NFC_OP_CMD && i_req.program_page &&
                       part_reg == `NFC_MAX_PARTIAL) begin
            lim_next = 1'b1; // R4
            rdy_next = 1'b1;
          end else begin
            if (i_req.op == NFC_OP_CMD && i_req.program_page) begin
              part_next = part_reg + 3'h1; // R4
            end
            // read bus turns round only while the port is released
            oe_next = (i_req.op == NFC_OP_CMD || i_req.op == NFC_OP_ADDR ||
                       i_req.op == NFC_OP_WDATA); // R13
            io_next = i_req.data;
            st_next = NFC_SETUP;
          end
        end
      end
      NFC_SETUP: begin
        cnt_next = STROBE_CYC;
        if (req_reg.op == NFC_OP_RDATA || req_reg.op == NFC_OP_ECC) begin
          ctl_next.output_strobe_n = 1'b0; // R18
        end else begin
          ctl_next.we_n = 1'b0;
        end
        st_next = NFC_PULSE;
      end
      NFC_PULSE: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          cnt_next = STROBE_CYC;
          if (!ctl_reg.output_strobe_n) begin
            // sample before rising edge; holds for normal and extended output
            rd_next = i_io_in; // R8 R9
            rv_next = 1'b1;
            if (req_reg.op == NFC_OP_ECC) begin
              ecc_next = ecc_reg - 3'h1; // R11
              if (ecc_reg == 3'h1) begin
                ecc_open_next = 1'b0;
              end
            end
          end
          ctl_next.we_n = 1'b1; // R15 R16
          ctl_next.output_strobe_n = 1'b1;
          st_next = NFC_HOLD;
        end
      end
      NFC_HOLD: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          ctl_next.cle = 1'b0;
          ctl_next.ale = 1'b0;
          oe_next = 1'b0;
          if (req_reg.op == NFC_OP_CMD && req_reg.data != `NFC_CMD_STATUS &&
              req_reg.data != `NFC_CMD_STATUS_MP && req_reg.data != `NFC_CMD_ECC) begin
            cnt_next = WB_CYC; // R14
            st_next = NFC_WB;
          end else begin
            rdy_next = 1'b1;
            st_next = NFC_IDLE;
          end
        end
      end
      NFC_WB: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          rdy_next = 1'b1;
          st_next = NFC_IDLE;
        end
      end
      NFC_BUSY: begin
        tmo_next = tmo_reg - TMO_W'(1);
        if (i_op_status_pin) begin
          // device raised ready; ecc status window closes until the next ecc command
          ecc_open_next = 1'b0; // R17 R12
          rdy_next = 1'b1;
          st_next = NFC_IDLE;
        end else if (tmo_reg == TMO_W'(0)) begin
          err_next = 1'b1; // R20
          rdy_next = 1'b1;
          st_next = NFC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_reg <= NFC_IDLE;
      req_reg <= '0;
      ctl_reg <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, output_strobe_n: 1'b1};
      cnt_reg <= 4'h0;
      tmo_reg <= '0;
      ecc_reg <= 3'h0;
      part_reg <= 3'h0;
      io_reg <= 8'h00;
      oe_reg <= 1'b0;
      rdy_reg <= 1'b1;
      rv_reg <= 1'b0;
      rd_reg <= 8'h00;
      err_reg <= 1'b0;
      lim_reg <= 1'b0;
      ecc_open_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      req_reg <= req_next;
      ctl_reg <= ctl_next;
      cnt_reg <= cnt_next;
      tmo_reg <= tmo_next;
      ecc_reg <= ecc_next;
      part_reg <= part_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      err_reg <= err_next;
      lim_reg <= lim_next;
      ecc_open_reg <= ecc_open_next;
    end
  end

  assign o_req_ready = rdy_reg;
  assign o_rdata_valid = rv_reg;
  assign o_rdata = rd_reg;
  assign o_timeout = err_reg;
  assign o_partial_limit = lim_reg;
  assign o_ctl = ctl_reg;
  assign o_io_out = io_reg;
  assign o_io_oe = oe_reg;
endmodule

/* testbench/nfc_dev_model.sv */
`timescale 1ns/100ps
module nfc_dev_model
  import nfc_pkg::*;
#(
  parameter logic [7:0] STATUS_BYTE = 8'he0
) (
  input wire logic i_mclk,
  input wire nfc_ctl_t i_ctl,
  input wire logic [7:0] i_io,
  input wire logic [15:0] i_busy_cyc,
  output logic [7:0] o_io,
  output logic o_op_status_pin
);
  nfc_ctl_t prv_reg = 5'h07;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] col_reg = 8'h00;
  logic [7:0] last_reg = 8'h00;
  logic drv_reg = 1'b0;
  int busy_reg = 0;
  int hold_reg = 0;
  always @(posedge i_mclk) begin
    prv_reg <= i_ctl;
    if (busy_reg != 0) busy_reg <= busy_reg - 1;
    if (hold_reg != 0) hold_reg <= hold_reg - 1;
    if (hold_reg == 1) drv_reg <= 1'b0;
    if (!prv_reg.we_n && i_ctl.we_n) begin
      col_reg <= 8'h00;
      if (i_ctl.cle) begin
        cmd_reg <= i_io;
        if (i_io inside {8'h10, 8'h11, 8'h30, 8'h35, 8'hd0, 8'hff}) busy_reg <= i_busy_cyc;
      end
    end
    if (prv_reg.output_strobe_n && !i_ctl.output_strobe_n) begin
      drv_reg <= 1'b1;
      hold_reg <= 0;
      last_reg <= (cmd_reg inside {8'h70, 8'h71}) ? STATUS_BYTE : col_reg;
      col_reg <= col_reg + 8'h01;
    end
    // short strobe high keeps data driven for a few cycles past the rise
    if (!prv_reg.output_strobe_n && i_ctl.output_strobe_n) hold_reg <= 3;
    if ((i_ctl.cle && !prv_reg.cle) || (i_ctl.ale && !prv_reg.ale) ||
        (i_ctl.ce_n && !prv_reg.ce_n) || (prv_reg.we_n && !i_ctl.we_n)) drv_reg <= 1'b0;
  end
  // released port shows the inverse of the last byte
  assign o_io = drv_reg ? last_reg : ~last_reg;
  assign o_op_status_pin = (busy_reg == 0);
endmodule

/* testbench/nfc_host_sva.sv */
`timescale 1ns/100ps
`include "nfc_regs.svh"
module nfc_host_chk
  import nfc_pkg::*;
#(
  parameter int unsigned T_PROG_CYC = 50,
  parameter int unsigned T_LOAD1_CYC = 50,
  parameter int unsigned T_LOADM_CYC = 50,
  parameter int unsigned T_ERASE_CYC = 50,
  parameter int unsigned T_RST_CYC = 50
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic o_req_ready,
  input wire logic o_rdata_valid,
  input wire logic o_timeout,
  input wire logic o_partial_limit,
  input wire nfc_ctl_t o_ctl,
  input wire logic [7:0] o_io_out,
  input wire logic o_io_oe,
  input wire logic i_op_status_pin
);
  function automatic int unsigned mx(input int unsigned a, input int unsigned b);
    return (a > b) ? a : b;
  endfunction
  localparam int unsigned STG = `NFC_T_STAGE_US * `NFC_US_CYC;
  localparam int unsigned LIM = mx(mx(mx(T_PROG_CYC, T_LOAD1_CYC), mx(T_LOADM_CYC, T_ERASE_CYC)),
    mx(T_RST_CYC, STG)) + 8;
  logic [31:0] wait_reg;
  logic [31:0] wait_next;
  always_comb wait_next = (!o_req_ready && !i_op_status_pin) ? wait_reg + 32'h1 : 32'h0;
  always_ff @(posedge i_mclk) wait_reg <= i_srst ? 32'h0 : wait_next;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  property p_no_drive_in_read;
    o_io_oe |-> o_ctl.output_strobe_n;
  endproperty
  a_no_drive_in_read: assert property (p_no_drive_in_read) else $error("port driven in read");
  property p_latch_excl;
    !(o_ctl.cle && o_ctl.ale);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latch enables high");
  property p_cmd_driven;
    $rose(o_ctl.we_n) && o_ctl.cle |-> o_io_oe && !o_ctl.ce_n;
  endproperty
  a_cmd_driven: assert property (p_cmd_driven) else $error("command latched undriven");
  property p_we_pulse;
    $fell(o_ctl.we_n) |=> !o_ctl.we_n ##1 o_ctl.we_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
  property p_read_pulse;
    $fell(o_ctl.output_strobe_n) |=> !o_ctl.output_strobe_n ##1 o_ctl.output_strobe_n;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read strobe width wrong");
  property p_byte_out;
    $rose(o_ctl.output_strobe_n) |-> o_rdata_valid ##1 !o_rdata_valid;
  endproperty
  a_byte_out: assert property (p_byte_out) else $error("read byte not delivered");
  property p_ecc_when_ready;
    o_ctl.cle && !o_ctl.we_n && o_io_out == `NFC_CMD_ECC |-> i_op_status_pin;
  endproperty
  a_ecc_when_ready: assert property (p_ecc_when_ready) else $error("ecc read while busy");
  property p_busy_bound;
    wait_reg <= LIM;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy wait not cut short");
  property p_partial_sticky;
    o_partial_limit |=> o_partial_limit;
  endproperty
  a_partial_sticky: assert property (p_partial_sticky) else $error("limit flag dropped");
  property p_timeout_ready;
    $rose(o_timeout) |-> ##[0:1] o_req_ready;
  endproperty
  a_timeout_ready: assert property (p_timeout_ready) else $error("no ready after timeout");
endmodule
bind nfc_host nfc_host_chk #(.T_PROG_CYC(T_PROG_CYC), .T_LOAD1_CYC(T_LOAD1_CYC),
  .T_LOADM_CYC(T_LOADM_CYC), .T_ERASE_CYC(T_ERASE_CYC), .T_RST_CYC(T_RST_CYC)) chk_u (
  .i_mclk, .i_srst, .o_req_ready, .o_rdata_valid, .o_timeout, .o_partial_limit, .o_ctl,
  .o_io_out, .o_io_oe, .i_op_status_pin);

/* testbench/test_nfc_host.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_nfc_host
  import nfc_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic req_valid = 1'b0;
  nfc_req_t req = '0;
  logic [15:0] busy_len = 16'h0014;
  logic ready, rdv, tout, plim, io_oe, pin;
  logic [7:0] rdata, io_out, io_in, mdl_io, rd;
  nfc_ctl_t ctl;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  // row: op, busy kind, byte, flags (1 program, 2 erase, 4 check), expected byte
  logic [27:0] rows [] = '{28'h0000000, 28'h1012000, 28'h0030000, 28'h4200000, 28'h007a000,
    28'h5000400, 28'h5000401, 28'h5000402, 28'h5000403, 28'h3000404, 28'h3000405,
    28'h0071000, 28'h30004e0, 28'h0000000, 28'h1012000, 28'h0030000, 28'h4300000,
    28'h0080000, 28'h1000000, 28'h20a5000, 28'h0011000, 28'h4100000, 28'h0081000,
    28'h1000000, 28'h205a000, 28'h0010100, 28'h4000000, 28'h0070000, 28'h30004e0,
    28'h00ff000, 28'h4500000, 28'h0060000, 28'h1000000, 28'h00d0200, 28'h4400000};
  always #5 i_mclk = ~i_mclk;
  assign io_in = io_oe ? io_out : mdl_io;
  nfc_host #(.T_PROG_CYC(50), .T_LOAD1_CYC(50), .T_LOADM_CYC(50), .T_ERASE_CYC(50),
    .T_RST_CYC(50)) dut_u (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(ready), .o_rdata_valid(rdv), .o_rdata(rdata), .o_timeout(tout),
    .o_partial_limit(plim), .o_ctl(ctl), .o_io_out(io_out), .o_io_oe(io_oe),
    .i_io_in(io_in), .i_op_status_pin(pin));
  nfc_dev_model mdl_u (.i_mclk(i_mclk), .i_ctl(ctl), .i_io(io_in), .i_busy_cyc(busy_len),
    .o_io(mdl_io), .o_op_status_pin(pin));
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic reset_dut();
    @(negedge i_mclk) i_srst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_srst = 1'b0;
  endtask
  task automatic run(input logic [27:0] r);
    int n;
    n = 0;
    rd = 8'hxx;
    @(negedge i_mclk);
    req_valid = 1'b1;
    req = '{op: nfc_op_t'(r[26:24]), busy_kind: nfc_busy_t'(r[22:20]), data: r[19:12],
      program_page: r[8], new_erase: r[9]};
    @(posedge i_mclk);
    do begin
      @(negedge i_mclk);
      req_valid = 1'b0;
      n++;
      if (rdv === 1'b1) rd = rdata;
    end while (ready !== 1'b1 && n < 3000);
    if (r[10]) `CHK(rd, r[7:0])
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    reset_dut();
    foreach (rows[i]) begin
      run(rows[i]);
      `CHK(tout, 1'b0)
    end
    for (int i = 0; i < 5; i++) begin
      `CHK(plim, 1'b0)
      run(28'h0010100);
      if (i < 4) run(28'h4000000);
    end
    `CHK(plim, 1'b1)
    reset_dut();
    `CHK({ready, ctl, io_oe, plim}, 8'h9c)
    run(28'h5000000);
    `CHK(plim, 1'b1)
    reset_dut();
    busy_len = 16'h00c8;
    run(28'h0010000);
    run(28'h4000000);
    `CHK(tout, 1'b1)
    run(28'h0070000);
    `CHK(tout, 1'b0)
    `CHK(plim, 1'b0)
    run(28'h007a000);
    `CHK(plim, 1'b1)
    conclude();
  end
endmodule
